// ---- gpio_pkg.sv ----
// What this block does
// - Each port data register is read/writable when mapped
// - Direction registers everywhere except input-only pins
// - All general-purpose pins are inputs after reset, except A/B whose enable follows the bus in expanded/peripheral modes
// - Ports A/B carry external bus in expanded modes
// - Port A data hidden in expanded/peripheral modes
// - Port B behaves and hides like port A
// - Direction one means output, zero means input
// - Port A direction hidden in expanded/peripheral modes
// - Port A direction resets to zero
// - Pull-up bit pulls up port A input pins in single-chip mode only
// - Pull-up control hidden in peripheral mode
// - Reduced-drive bit weakens port A outputs
// - Reduced-drive control accepts first write only
// - Reduced-drive control hidden in peripheral mode
// - Ports H/J key wake-up flags on pin edges
// - Polarity one rising, zero falling, resets zero
package gpio_pkg;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXPANDED,
    MODE_PERIPHERAL
  } mode_e;

  // Port indices; A and B double as the external bus
  localparam int NPORT = 4;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int PORT_H = 2;
  localparam int PORT_J = 3;
  localparam int NWAKE = 2;
  localparam int PORT_W = 8;

  // Register offsets, byte addresses on the APB
  localparam logic [11:0] DATA_BASE = 12'h000;
  localparam logic [11:0] DIR_BASE = 12'h004;
  localparam logic [11:0] PORT_STRIDE = 12'h008;
  localparam logic [11:0] PULL_OFF = 12'h020;
  localparam logic [11:0] RDRV_OFF = 12'h024;
  localparam logic [11:0] WPOL_BASE = 12'h028;
  localparam logic [11:0] WFLAG_BASE = 12'h030;
  localparam logic [11:0] WIEN_BASE = 12'h038;
  localparam logic [11:0] WAKE_STRIDE = 12'h004;
  localparam logic [11:0] ANALOG0_OFF = 12'h040;
  localparam logic [11:0] ANALOG1_OFF = 12'h044;
  localparam logic [11:0] PE_IN_OFF = 12'h048;

  // Reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] WPOL_RST = 8'h00;
  localparam logic [3:0] PULL_RST = 4'h0;
  localparam logic [3:0] RDRV_RST = 4'h0;

  function automatic logic [11:0] data_off(input int p);
    return DATA_BASE + 12'(p) * PORT_STRIDE;
  endfunction

  function automatic logic [11:0] dir_off(input int p);
    return DIR_BASE + 12'(p) * PORT_STRIDE;
  endfunction

  function automatic logic [11:0] wake_off(input logic [11:0] base,
                                           input int w);
    return base + 12'(w) * WAKE_STRIDE;
  endfunction

endpackage

// ---- gpio_pin_bank.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_bank #(
  parameter int W = 8
) (
  input wire logic i_clk,            // System clock
  input wire logic i_rst,            // Sync reset, high
  input wire logic [W-1:0] i_dir,    // One = output
  input wire logic [W-1:0] i_data,   // Stored data bits
  input wire logic [W-1:0] i_pin,    // Pin levels
  input wire logic i_bus_own,        // External bus owns pins
  input wire logic [W-1:0] i_bus_out, // Bus value to drive
  input wire logic i_bus_oe,         // Bus drive enable
  input wire logic i_pull_en,        // Port pull-up enable
  input wire logic i_reduce_en,      // Port reduced drive
  output logic [W-1:0] o_out,        // Pin output value
  output logic [W-1:0] o_oe,         // Pin output enable
  output logic [W-1:0] o_pull,       // Pull-up per pin
  output logic [W-1:0] o_reduced,    // Reduced drive per pin
  output logic [W-1:0] o_sampled     // Registered pin level
);

  typedef struct packed {
    logic [W-1:0] sampled;
  } bank_s;

  bank_s st_q;
  bank_s st_d;

  // Pin levels sampled once so reads and edge logic agree
  always_comb begin
    st_d = st_q;
    st_d.sampled = i_pin;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Bus ownership bypasses direction and data entirely
  always_comb begin
    if (i_bus_own) begin
      o_out = i_bus_out;
      o_oe = {W{i_bus_oe}};
      o_pull = '0;
    end else begin
      o_out = i_data;
      o_oe = i_dir;
      o_pull = {W{i_pull_en}} & ~i_dir;
    end
    o_reduced = {W{i_reduce_en}} & o_oe;
    o_sampled = st_q.sampled;
  end

endmodule
`default_nettype wire

// ---- key_wakeup.sv ----
`timescale 1ns/1ps
`default_nettype none
module key_wakeup #(
  parameter int W = 8
) (
  input wire logic i_clk,            // System clock
  input wire logic i_rst,            // Sync reset, high
  input wire logic [W-1:0] i_pin,    // Sampled pin levels
  input wire logic [W-1:0] i_polarity, // One = rising edge
  input wire logic [W-1:0] i_enable, // Interrupt enables
  input wire logic [W-1:0] i_clear,  // Write-one-to-clear
  output logic [W-1:0] o_flags,      // Sticky edge flags
  output logic o_irq                 // Any enabled flag
);

  typedef struct packed {
    logic armed;
    logic [W-1:0] prev;
    logic [W-1:0] flags;
  } wake_s;

  wake_s st_q;
  wake_s st_d;
  logic [W-1:0] edge_hit;

  // First cycle after reset only loads history, no false edge
  always_comb begin
    st_d = st_q;
    st_d.armed = 1'b1;
    st_d.prev = i_pin;
    edge_hit = (i_polarity & ~st_q.prev & i_pin) |
               (~i_polarity & st_q.prev & ~i_pin);
    if (!st_q.armed) begin
      edge_hit = '0;
    end
    // New edge wins over a clear in the same cycle
    st_d.flags = (st_q.flags & ~i_clear) | edge_hit;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_flags = st_q.flags;
  assign o_irq = |(st_q.flags & i_enable);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_rise_sets_flag: assert property (
    st_q.armed && i_polarity[0] && !st_q.prev[0] && i_pin[0]
    |=> st_q.flags[0])
    else $error("rising edge did not set flag");
  a_fall_ignored: assert property (
    st_q.armed && i_polarity[0] && st_q.prev[0] && !i_pin[0] &&
    !st_q.flags[0] |=> !st_q.flags[0])
    else $error("falling edge set flag in rising mode");
  c_wake_irq: cover property (o_irq);

endmodule
`default_nettype wire

// ---- mode_gated_gpio_ports.sv ----
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mode_gated_gpio_ports #(
  parameter int W = gpio_pkg::PORT_W
) (
  input wire logic i_clk,              // System clock, 100 MHz
  input wire logic i_rst,              // Sync reset, high
  input wire gpio_pkg::mode_e i_mode,  // Operating mode
  // APB slave
  input wire logic psel,               // Select
  input wire logic penable,            // Access phase
  input wire logic pwrite,             // Write
  input wire logic [11:0] paddr,       // Byte address
  input wire logic [31:0] pwdata,      // Write data
  output logic [31:0] prdata,          // Read data
  output logic pready,                 // Always ready
  output logic pslverr,                // Unmapped or hidden
  // External bus values for ports A and B
  input wire logic [W-1:0] i_ext_a_out, // Bus onto port A
  input wire logic [W-1:0] i_ext_b_out, // Bus onto port B
  input wire logic i_ext_oe,           // Bus drives pins
  // Port A pins
  input wire logic [W-1:0] i_pa_pin,   // Pin level
  output logic [W-1:0] o_pa_out,       // Drive value
  output logic [W-1:0] o_pa_oe,        // Drive enable
  output logic [W-1:0] o_pa_pull,      // Pull-up on
  output logic [W-1:0] o_pa_reduced,   // Reduced drive
  // Port B pins
  input wire logic [W-1:0] i_pb_pin,   // Pin level
  output logic [W-1:0] o_pb_out,       // Drive value
  output logic [W-1:0] o_pb_oe,        // Drive enable
  output logic [W-1:0] o_pb_pull,      // Pull-up on
  output logic [W-1:0] o_pb_reduced,   // Reduced drive
  // Port H pins
  input wire logic [W-1:0] i_ph_pin,   // Pin level
  output logic [W-1:0] o_ph_out,       // Drive value
  output logic [W-1:0] o_ph_oe,        // Drive enable
  output logic [W-1:0] o_ph_pull,      // Pull on
  output logic [W-1:0] o_ph_reduced,   // Reduced drive
  // Port J pins
  input wire logic [W-1:0] i_pj_pin,   // Pin level
  output logic [W-1:0] o_pj_out,       // Drive value
  output logic [W-1:0] o_pj_oe,        // Drive enable
  output logic [W-1:0] o_pj_pull,      // Pull on
  output logic [W-1:0] o_pj_reduced,   // Reduced drive
  // Input-only pins
  input wire logic [W-1:0] i_analog_port_zero, // Digital view
  input wire logic [W-1:0] i_analog_port_one,  // Digital view
  input wire logic [1:0] i_port_e_input_only_pins, // Levels
  // Key wake-up interrupts
  output logic o_wake_irq_h,           // Port H request
  output logic o_wake_irq_j            // Port J request
);

  typedef struct packed {
    logic [gpio_pkg::NPORT-1:0][W-1:0] data;
    logic [gpio_pkg::NPORT-1:0][W-1:0] dir;
    logic [gpio_pkg::NWAKE-1:0][W-1:0] wpol;
    logic [gpio_pkg::NWAKE-1:0][W-1:0] wien;
    logic [3:0] pull;
    logic [3:0] rdrv;
    logic rdrv_done;
    logic [31:0] prdata;
  } regs_s;

  regs_s st_q;
  regs_s st_d;

  logic [gpio_pkg::NPORT-1:0][W-1:0] pin_in;
  logic [gpio_pkg::NPORT-1:0][W-1:0] pin_out;
  logic [gpio_pkg::NPORT-1:0][W-1:0] pin_oe;
  logic [gpio_pkg::NPORT-1:0][W-1:0] pin_pull;
  logic [gpio_pkg::NPORT-1:0][W-1:0] pin_red;
  logic [gpio_pkg::NPORT-1:0][W-1:0] sampled;
  logic [gpio_pkg::NPORT-1:0][W-1:0] bus_val;
  logic [gpio_pkg::NWAKE-1:0][W-1:0] wflags;
  logic [gpio_pkg::NWAKE-1:0][W-1:0] wclear;
  logic [gpio_pkg::NWAKE-1:0] wirq;
  logic bus_mode;
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic mapped;
  logic [W-1:0] rd_val;

  // Visibility of a register in the current mode
  function automatic logic reg_visible(input logic [11:0] a,
                                       input gpio_pkg::mode_e m);
    logic vis;
    vis = 1'b0;
    for (int p = 0; p < gpio_pkg::NPORT; p++) begin
      if (a == gpio_pkg::data_off(p) || a == gpio_pkg::dir_off(p)) begin
        // A and B leave the map whenever the bus uses them
        vis = (p >= gpio_pkg::PORT_H) || (m == gpio_pkg::MODE_SINGLE);
      end
    end
    if (a == gpio_pkg::PULL_OFF || a == gpio_pkg::RDRV_OFF) begin
      vis = (m != gpio_pkg::MODE_PERIPHERAL);
    end
    for (int w = 0; w < gpio_pkg::NWAKE; w++) begin
      if (a == gpio_pkg::wake_off(gpio_pkg::WPOL_BASE, w) ||
          a == gpio_pkg::wake_off(gpio_pkg::WFLAG_BASE, w) ||
          a == gpio_pkg::wake_off(gpio_pkg::WIEN_BASE, w)) begin
        vis = 1'b1;
      end
    end
    if (a == gpio_pkg::ANALOG0_OFF || a == gpio_pkg::ANALOG1_OFF ||
        a == gpio_pkg::PE_IN_OFF) begin
      vis = 1'b1;
    end
    return vis;
  endfunction

  assign pin_in[gpio_pkg::PORT_A] = i_pa_pin;
  assign pin_in[gpio_pkg::PORT_B] = i_pb_pin;
  assign pin_in[gpio_pkg::PORT_H] = i_ph_pin;
  assign pin_in[gpio_pkg::PORT_J] = i_pj_pin;
  assign bus_val[gpio_pkg::PORT_A] = i_ext_a_out;
  assign bus_val[gpio_pkg::PORT_B] = i_ext_b_out;
  assign bus_val[gpio_pkg::PORT_H] = '0;
  assign bus_val[gpio_pkg::PORT_J] = '0;
  assign bus_mode = (i_mode != gpio_pkg::MODE_SINGLE);

  // One pin bank per port; only A and B can be taken by the bus
  for (genvar p = 0; p < gpio_pkg::NPORT; p++) begin : g_bank
    gpio_pin_bank #(
      .W(W)
    ) u_bank (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_dir(st_q.dir[p]),
      .i_data(st_q.data[p]),
      .i_pin(pin_in[p]),
      .i_bus_own(bus_mode && (p < gpio_pkg::PORT_H)),
      .i_bus_out(bus_val[p]),
      .i_bus_oe(i_ext_oe),
      .i_pull_en(st_q.pull[p]),
      .i_reduce_en(st_q.rdrv[p]),
      .o_out(pin_out[p]),
      .o_oe(pin_oe[p]),
      .o_pull(pin_pull[p]),
      .o_reduced(pin_red[p]),
      .o_sampled(sampled[p])
    );
  end

  // Wake-up logic for ports H and J
  for (genvar w = 0; w < gpio_pkg::NWAKE; w++) begin : g_wake
    key_wakeup #(
      .W(W)
    ) u_wake (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(sampled[gpio_pkg::PORT_H + w]),
      .i_polarity(st_q.wpol[w]),
      .i_enable(st_q.wien[w]),
      .i_clear(wclear[w]),
      .o_flags(wflags[w]),
      .o_irq(wirq[w])
    );
  end

  assign o_pa_out = pin_out[gpio_pkg::PORT_A];
  assign o_pa_oe = pin_oe[gpio_pkg::PORT_A];
  assign o_pa_pull = pin_pull[gpio_pkg::PORT_A];
  assign o_pa_reduced = pin_red[gpio_pkg::PORT_A];
  assign o_pb_out = pin_out[gpio_pkg::PORT_B];
  assign o_pb_oe = pin_oe[gpio_pkg::PORT_B];
  assign o_pb_pull = pin_pull[gpio_pkg::PORT_B];
  assign o_pb_reduced = pin_red[gpio_pkg::PORT_B];
  assign o_ph_out = pin_out[gpio_pkg::PORT_H];
  assign o_ph_oe = pin_oe[gpio_pkg::PORT_H];
  assign o_ph_pull = pin_pull[gpio_pkg::PORT_H];
  assign o_ph_reduced = pin_red[gpio_pkg::PORT_H];
  assign o_pj_out = pin_out[gpio_pkg::PORT_J];
  assign o_pj_oe = pin_oe[gpio_pkg::PORT_J];
  assign o_pj_pull = pin_pull[gpio_pkg::PORT_J];
  assign o_pj_reduced = pin_red[gpio_pkg::PORT_J];
  assign o_wake_irq_h = wirq[0];
  assign o_wake_irq_j = wirq[1];

  // APB phases; zero wait states, read data latched in setup
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en = access_ph && pwrite;
  assign mapped = reg_visible(paddr, i_mode);
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = st_q.prdata;

  // Register next state, read mux and wake flag clears
  always_comb begin
    st_d = st_q;
    rd_val = '0;
    wclear = '0;
    for (int p = 0; p < gpio_pkg::NPORT; p++) begin
      if (paddr == gpio_pkg::data_off(p)) begin
        // Output bits read back data, input bits the pin
        rd_val = (st_q.dir[p] & st_q.data[p]) |
                 (~st_q.dir[p] & sampled[p]);
      end
      if (paddr == gpio_pkg::dir_off(p)) begin
        rd_val = st_q.dir[p];
      end
      if (wr_en && mapped && paddr == gpio_pkg::data_off(p)) begin
        st_d.data[p] = pwdata[W-1:0];
      end
      if (wr_en && mapped && paddr == gpio_pkg::dir_off(p)) begin
        st_d.dir[p] = pwdata[W-1:0];
      end
    end
    for (int w = 0; w < gpio_pkg::NWAKE; w++) begin
      if (paddr == gpio_pkg::wake_off(gpio_pkg::WPOL_BASE, w)) begin
        rd_val = st_q.wpol[w];
        if (wr_en) begin
          st_d.wpol[w] = pwdata[W-1:0];
        end
      end
      if (paddr == gpio_pkg::wake_off(gpio_pkg::WFLAG_BASE, w)) begin
        rd_val = wflags[w];
        if (wr_en) begin
          wclear[w] = pwdata[W-1:0];
        end
      end
      if (paddr == gpio_pkg::wake_off(gpio_pkg::WIEN_BASE, w)) begin
        rd_val = st_q.wien[w];
        if (wr_en) begin
          st_d.wien[w] = pwdata[W-1:0];
        end
      end
    end
    if (paddr == gpio_pkg::PULL_OFF) begin
      rd_val = W'(st_q.pull);
      if (wr_en && mapped) begin
        st_d.pull = pwdata[3:0];
      end
    end
    // Drive strength is locked after one write so errant code
    // cannot weaken outputs later
    if (paddr == gpio_pkg::RDRV_OFF) begin
      rd_val = W'(st_q.rdrv);
      if (wr_en && mapped && !st_q.rdrv_done) begin
        st_d.rdrv = pwdata[3:0];
        st_d.rdrv_done = 1'b1;
      end
    end
    // Input-only groups have no direction register
    if (paddr == gpio_pkg::ANALOG0_OFF) begin
      rd_val = i_analog_port_zero;
    end
    if (paddr == gpio_pkg::ANALOG1_OFF) begin
      rd_val = i_analog_port_one;
    end
    if (paddr == gpio_pkg::PE_IN_OFF) begin
      rd_val = W'(i_port_e_input_only_pins);
    end
    if (setup_ph) begin
      st_d.prdata = mapped ? 32'(rd_val) : 32'h0000_0000;
    end
  end

  // Reset clears data and direction, leaving every pin not owned by the bus an input
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q.data <= {gpio_pkg::NPORT{gpio_pkg::DATA_RST}};
      st_q.dir <= {gpio_pkg::NPORT{gpio_pkg::DIR_RST}};
      st_q.wpol <= {gpio_pkg::NWAKE{gpio_pkg::WPOL_RST}};
      st_q.wien <= '0;
      st_q.pull <= gpio_pkg::PULL_RST;
      st_q.rdrv <= gpio_pkg::RDRV_RST;
      st_q.rdrv_done <= 1'b0;
      st_q.prdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_reset_inputs: assert property ($past(i_rst) |->
    o_pa_oe == 8'h00 && o_ph_oe == 8'h00 && o_pj_oe == 8'h00)
    else $error("pin driven right after reset");
  a_porta_hidden: assert property (
    wr_en && paddr == gpio_pkg::DATA_BASE && bus_mode
    |=> $stable(st_q.data[0]) && $past(pslverr))
    else $error("hidden port A data was written");
  a_portb_hidden: assert property (
    wr_en && paddr == 12'h008 && bus_mode |=> $stable(st_q.data[1]))
    else $error("hidden port B data was written");
  a_dira_hidden: assert property (
    wr_en && paddr == gpio_pkg::DIR_BASE && bus_mode
    |=> $stable(st_q.dir[0]))
    else $error("hidden port A direction was written");
  a_dira_write: assert property (
    wr_en && paddr == gpio_pkg::DIR_BASE && !bus_mode
    |=> o_pa_oe == $past(pwdata[7:0]))
    else $error("direction write did not reach pins");
  a_pull_hidden: assert property (
    wr_en && paddr == gpio_pkg::PULL_OFF &&
    i_mode == gpio_pkg::MODE_PERIPHERAL |=> $stable(st_q.pull))
    else $error("pull control written in peripheral mode");
  a_rdrv_once: assert property (
    st_q.rdrv_done |=> $stable(st_q.rdrv))
    else $error("reduced drive changed after first write");
  a_rdrv_hidden: assert property (
    wr_en && paddr == gpio_pkg::RDRV_OFF &&
    i_mode == gpio_pkg::MODE_PERIPHERAL && !st_q.rdrv_done
    |=> !st_q.rdrv_done)
    else $error("reduced drive written in peripheral mode");
  a_reduced_out: assert property (
    st_q.rdrv[0] && o_pa_oe[0] |-> o_pa_reduced[0])
    else $error("port A output not reduced");
  a_pullup_in: assert property (
    st_q.pull[0] && !bus_mode && !st_q.dir[0][0] |-> o_pa_pull[0])
    else $error("port A input not pulled up");
  a_bus_owns: assert property (
    bus_mode |-> o_pa_out == i_ext_a_out &&
    o_pb_oe == {8{i_ext_oe}})
    else $error("bus mode pins follow registers");
  a_read_pin: assert property (
    setup_ph && paddr == 12'h010 && st_q.dir[2] == 8'h00
    |=> prdata[7:0] == $past(sampled[2]))
    else $error("input read did not return pin level");

  c_write_dir: cover property (wr_en && paddr == gpio_pkg::DIR_BASE);
  c_bus_mode: cover property (bus_mode && i_ext_oe);
  c_rdrv_locked: cover property (st_q.rdrv_done && wr_en &&
    paddr == gpio_pkg::RDRV_OFF);

endmodule
`default_nettype wire

// ---- pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input wire logic i_clk,          // Bench clock
  input wire logic [7:0] i_out,    // Device drive value
  input wire logic [7:0] i_oe,     // Device drive enable
  input wire logic [7:0] i_pull,   // Device pull-up
  input wire logic [7:0] i_force,  // Far side drives
  input wire logic [7:0] i_level,  // Far side level
  output logic [7:0] o_pin         // Resolved pin level
);
  logic [7:0] float_q = 8'h55;
  // Undriven pins wander, so a stale value never passes for a read
  always @(posedge i_clk) float_q <= ~float_q;
  // Device drive wins, then far side, then pull-up
  assign o_pin = (i_oe & i_out) | (~i_oe & i_force & i_level)
    | (~i_oe & ~i_force & (i_pull | float_q));
endmodule
`default_nettype wire

// ---- mode_gated_gpio_ports_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module mode_gated_gpio_ports_tb;
  localparam logic [11:0] A_DAT = gpio_pkg::DATA_BASE;
  localparam logic [11:0] A_DIR = gpio_pkg::DIR_BASE;
  localparam logic [11:0] B_DAT = A_DAT + gpio_pkg::PORT_STRIDE;
  localparam logic [11:0] B_DIR = A_DIR + gpio_pkg::PORT_STRIDE;
  localparam logic [11:0] PULL = gpio_pkg::PULL_OFF;
  localparam logic [11:0] RDRV = gpio_pkg::RDRV_OFF;
  localparam logic [11:0] JIEN = gpio_pkg::WIEN_BASE + gpio_pkg::WAKE_STRIDE;
  logic i_clk, i_rst, psel, penable, pwrite, pready, pslverr, i_ext_oe, err;
  logic irq_h, irq_j;
  gpio_pkg::mode_e i_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ext_a, ext_b, an0, an1;
  logic [1:0] pe;
  logic [7:0] po[4], poe[4], ppl[4], prd[4], pin[4], frc[4], lvl[4];
  int fails, checked;

  mode_gated_gpio_ports DUT (.i_clk(i_clk), .i_rst(i_rst), .i_mode(i_mode),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_ext_a_out(ext_a), .i_ext_b_out(ext_b), .i_ext_oe(i_ext_oe),
    .i_pa_pin(pin[0]), .o_pa_out(po[0]), .o_pa_oe(poe[0]),
    .o_pa_pull(ppl[0]), .o_pa_reduced(prd[0]),
    .i_pb_pin(pin[1]), .o_pb_out(po[1]), .o_pb_oe(poe[1]),
    .o_pb_pull(ppl[1]), .o_pb_reduced(prd[1]),
    .i_ph_pin(pin[2]), .o_ph_out(po[2]), .o_ph_oe(poe[2]),
    .o_ph_pull(ppl[2]), .o_ph_reduced(prd[2]),
    .i_pj_pin(pin[3]), .o_pj_out(po[3]), .o_pj_oe(poe[3]),
    .o_pj_pull(ppl[3]), .o_pj_reduced(prd[3]),
    .i_analog_port_zero(an0), .i_analog_port_one(an1),
    .i_port_e_input_only_pins(pe), .o_wake_irq_h(irq_h),
    .o_wake_irq_j(irq_j));

  // One far-side model per port
  for (genvar k = 0; k < 4; k++) begin : g_pins
    pin_partner u_pins (.i_clk(i_clk), .i_out(po[k]), .i_oe(poe[k]),
      .i_pull(ppl[k]), .i_force(frc[k]), .i_level(lvl[k]), .o_pin(pin[k]));
  end

  // Clock, 100 MHz
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // APB transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Read, then compare data and error flag
  task automatic rdc(input logic [11:0] a, input logic [31:0] e,
                     input logic ee);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check({31'h0, err}, {31'h0, ee});
  endtask

  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic do_reset;
    i_rst <= 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask

  // Watchdog, far beyond the roughly 150 cycles the tests need
  initial begin
    repeat (3000) @(posedge i_clk);
    fails++;
    results;
  end

  initial begin
    i_rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    i_mode = gpio_pkg::MODE_SINGLE;
    {ext_a, ext_b, i_ext_oe} = {8'h3c, 8'hc3, 1'b1};
    {an0, an1, pe} = {8'h96, 8'h69, 2'b10};
    foreach (frc[k]) {frc[k], lvl[k]} = {8'hff, 8'h00};
    fails = 0;
    checked = 0;
    do_reset();
    check({poe[0], poe[1], poe[2], poe[3]}, 32'h0);
    rdc(A_DIR, 32'h0, 1'b0);
    rdc(gpio_pkg::WPOL_BASE, 32'h0, 1'b0);
    $display("test reset done");
    // Single-chip: plain I/O, all registers mapped
    wr(A_DIR, 32'hf0);
    wr(A_DAT, 32'ha5);
    lvl[0] <= 8'h03;
    @(negedge i_clk); // Pins follow the write only after its edge
    check({16'h0, poe[0], po[0]}, 32'hf0a5);
    repeat (2) @(posedge i_clk);
    rdc(A_DAT, 32'ha3, 1'b0);
    wr(B_DIR, 32'h0f);
    wr(B_DAT, 32'h5a);
    rdc(B_DIR, 32'h0f, 1'b0);
    check({16'h0, poe[1], po[1]}, 32'h0f5a);
    wr(PULL, 32'h1);
    @(negedge i_clk);
    check({16'h0, ppl[0], ppl[1]}, 32'h0f00);
    wr(RDRV, 32'h1);
    @(negedge i_clk);
    check({16'h0, prd[0], prd[1]}, 32'hf000);
    wr(RDRV, 32'h2);
    rdc(RDRV, 32'h1, 1'b0);
    wr(gpio_pkg::ANALOG0_OFF, 32'hff);
    rdc(gpio_pkg::ANALOG0_OFF, {24'h0, an0}, 1'b0);
    rdc(gpio_pkg::ANALOG1_OFF, {24'h0, an1}, 1'b0);
    rdc(gpio_pkg::PE_IN_OFF, {30'h0, pe}, 1'b0);
    rdc(12'h0fc, 32'h0, 1'b1);
    $display("test single mode done");
    // Expanded: A and B belong to the external bus
    i_mode <= gpio_pkg::MODE_EXPANDED;
    wr(A_DIR, 32'hff);
    rdc(A_DAT, 32'h0, 1'b1);
    rdc(A_DIR, 32'h0, 1'b1);
    wr(B_DAT, 32'hff);
    rdc(B_DAT, 32'h0, 1'b1);
    rdc(PULL, 32'h1, 1'b0);
    check({po[0], poe[0], po[1], poe[1]},
      {ext_a, 8'hff, ext_b, 8'hff});
    i_ext_oe <= 1'b0;
    repeat (2) @(posedge i_clk);
    check({poe[0], poe[1], ppl[0], ppl[1]}, 32'h0);
    i_mode <= gpio_pkg::MODE_PERIPHERAL;
    rdc(PULL, 32'h0, 1'b1);
    rdc(RDRV, 32'h0, 1'b1);
    wr(PULL, 32'hf);
    i_mode <= gpio_pkg::MODE_SINGLE;
    rdc(A_DIR, 32'hf0, 1'b0);
    rdc(PULL, 32'h1, 1'b0);
    rdc(B_DAT, 32'h0a, 1'b0);
    $display("test bus modes done");
    // Wake-up: H rising, J falling
    wr(gpio_pkg::WPOL_BASE, 32'h1);
    wr(gpio_pkg::WIEN_BASE, 32'h1);
    wr(JIEN, 32'h80);
    lvl[2] <= 8'h01;
    lvl[3] <= 8'h80;
    repeat (4) @(posedge i_clk);
    check({30'h0, irq_h, irq_j}, 32'h2);
    rdc(gpio_pkg::data_off(gpio_pkg::PORT_H), 32'h1, 1'b0);
    rdc(gpio_pkg::WFLAG_BASE, 32'h1, 1'b0);
    wr(gpio_pkg::WFLAG_BASE, 32'h1);
    lvl[2] <= 8'h00;
    lvl[3] <= 8'h00;
    repeat (4) @(posedge i_clk);
    check({30'h0, irq_h, irq_j}, 32'h1);
    rdc(gpio_pkg::WFLAG_BASE, 32'h0, 1'b0);
    $display("test wake-up done");
    // A second reset reopens the one-time write
    do_reset();
    check({poe[0], poe[1], poe[2], poe[3]}, 32'h0);
    i_mode <= gpio_pkg::MODE_PERIPHERAL;
    wr(RDRV, 32'h4);
    i_mode <= gpio_pkg::MODE_SINGLE;
    wr(RDRV, 32'h2);
    rdc(RDRV, 32'h2, 1'b0);
    wr(PULL, 32'hc);
    @(negedge i_clk);
    check({ppl[2], ppl[3], po[2], po[3]}, 32'hffff_0000);
    rdc(A_DIR, 32'h0, 1'b0);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
